// ---- include/wdr_pkg.sv ----
package wdr_pkg;
  localparam logic [15:0] WDR_MODE_ADDR = 16'hff98;
  localparam logic [15:0] WDR_KEY_ADDR = 16'hff99;
  localparam logic [7:0] WDR_MODE_RST = 8'h67;
  localparam logic [7:0] WDR_KEY_RST = 8'h9a;
  localparam logic [7:0] WDR_KEY_VAL = 8'hac;
  localparam logic [2:0] WDR_MODE_FIXED = 3'h3;
  localparam int WDR_FIXED_LSB = 5;
  localparam int WDR_STOP_BIT = 4;
  localparam int WDR_SRC_BIT = 3;
  localparam int WDR_CODE_MSB = 2;
  localparam int WDR_OSC_BASE_EXP = 11;
  localparam int WDR_HS_BASE_EXP = 13;
  localparam int WDR_CNT_W = 21;
endpackage

// ---- verilog/wdr_watchdog.sv ----
`timescale 1ns/1ps
module wdr_watchdog
  import wdr_pkg::*;
#(
  parameter int CNT_W = WDR_CNT_W
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic bit_acc_i,
  input wire logic always_run_opt_i,
  input wire logic osc_tick_i,
  input wire logic hs_tick_i,
  input wire logic src_stopped_i,
  output logic [7:0] rdata_o,
  output logic stopped_o,
  output logic wdt_reset_o
);

  if (CNT_W < WDR_HS_BASE_EXP + 8) begin : g_cnt_w_chk
    $error("CNT_W too small for longest interval");
  end

  function automatic logic [CNT_W-1:0] ovf_limit(input logic [2:0] code,
                                                 input logic hs);
    logic [CNT_W-1:0] one;
    one = {{(CNT_W-1){1'b0}}, 1'b1};
    if (hs) begin
      ovf_limit = one << (WDR_HS_BASE_EXP + int'(code));
    end else begin
      ovf_limit = one << (WDR_OSC_BASE_EXP + int'(code));
    end
  endfunction

  logic [7:0] mode_r, mode_nxt;
  logic mode_done_r, mode_done_nxt;
  logic stop_r, stop_nxt;
  logic hs_sel_r, hs_sel_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic pend_r, pend_nxt;
  logic fired_r, fired_nxt;
  logic [7:0] rdata_nxt;
  logic rst_pulse_nxt;
  logic tick, ovf, key_wr, key_bad, key_bit, mode_wr, cause;

  always_comb begin
    // Selected source tick, none when stopped
    tick = stop_r ? 1'b0 : (hs_sel_r ? hs_tick_i : osc_tick_i);
    ovf = tick && (cnt_r == ovf_limit(mode_r[WDR_CODE_MSB:0], hs_sel_r)
                   - {{(CNT_W-1){1'b0}}, 1'b1});
    key_wr = wr_i && !bit_acc_i && (addr_i == WDR_KEY_ADDR);
    key_bit = bit_acc_i && (wr_i || rd_i) && (addr_i == WDR_KEY_ADDR);
    key_bad = key_wr && (wdata_i != WDR_KEY_VAL);
    mode_wr = wr_i && !bit_acc_i && (addr_i == WDR_MODE_ADDR);
    cause = !stop_r && (ovf || key_bad || key_bit ||
                        (mode_wr && mode_done_r));

    mode_nxt = mode_r;
    mode_done_nxt = mode_done_r;
    stop_nxt = stop_r;
    hs_sel_nxt = hs_sel_r;
    cnt_nxt = tick ? cnt_r + {{(CNT_W-1){1'b0}}, 1'b1} : cnt_r;
    pend_nxt = pend_r;
    fired_nxt = fired_r;
    rst_pulse_nxt = 1'b0;
    rdata_nxt = 8'h00;

    if (key_wr && !key_bad) begin
      cnt_nxt = '0;
    end
    if (mode_wr && !mode_done_r) begin
      mode_done_nxt = 1'b1;
      mode_nxt[WDR_CODE_MSB:0] = wdata_i[WDR_CODE_MSB:0];
      cnt_nxt = '0;
      if (!always_run_opt_i) begin
        mode_nxt[WDR_STOP_BIT] = wdata_i[WDR_STOP_BIT];
        mode_nxt[WDR_SRC_BIT] = wdata_i[WDR_SRC_BIT];
        stop_nxt = wdata_i[WDR_STOP_BIT];
        hs_sel_nxt = wdata_i[WDR_SRC_BIT] && !wdata_i[WDR_STOP_BIT];
      end
    end
    if (always_run_opt_i) begin
      stop_nxt = 1'b0;
      hs_sel_nxt = 1'b0;
    end
    if (cause && src_stopped_i) begin
      pend_nxt = 1'b1;
    end
    if ((cause || pend_r) && !src_stopped_i && !fired_r) begin
      rst_pulse_nxt = 1'b1;
      fired_nxt = 1'b1;
      pend_nxt = 1'b0;
    end
    if (rd_i && !bit_acc_i) begin
      if (addr_i == WDR_KEY_ADDR) begin
        rdata_nxt = WDR_KEY_RST;
      end else if (addr_i == WDR_MODE_ADDR) begin
        rdata_nxt = mode_r;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_r <= WDR_MODE_RST;
      mode_done_r <= 1'b0;
      stop_r <= 1'b0;
      hs_sel_r <= 1'b0;
      cnt_r <= '0;
      pend_r <= 1'b0;
      fired_r <= 1'b0;
      rdata_o <= 8'h00;
      stopped_o <= 1'b0;
      wdt_reset_o <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      mode_done_r <= mode_done_nxt;
      stop_r <= stop_nxt;
      hs_sel_r <= hs_sel_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      fired_r <= fired_nxt;
      rdata_o <= rdata_nxt;
      stopped_o <= stop_nxt;
      wdt_reset_o <= rst_pulse_nxt;
    end
  end

  a_key_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
    (key_wr && !key_bad && !ovf) |=> (cnt_r == '0))
    else $error("Key write did not clear counter");

  a_mode_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode_wr && !mode_done_r) |=> (cnt_r == '0))
    else $error("Mode write did not clear counter");

  a_bad_key_rst: assert property (@(posedge mclk_i) disable iff (rst_i)
    (key_bad && !stop_r && !src_stopped_i && !fired_r) |=> wdt_reset_o)
    else $error("Wrong key did not raise reset");

  a_bit_acc_rst: assert property (@(posedge mclk_i) disable iff (rst_i)
    (key_bit && !stop_r && !src_stopped_i && !fired_r) |=> wdt_reset_o)
    else $error("Bit access did not raise reset");

  a_defer_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pend_r && src_stopped_i) |=> !wdt_reset_o ##0 pend_r)
    else $error("Deferred reset escaped while stopped");

  a_key_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_i && !bit_acc_i && addr_i == WDR_KEY_ADDR) |=>
      (rdata_o == WDR_KEY_RST))
    else $error("Key register read wrong value");

  a_ovf_rst: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ovf && !src_stopped_i && !fired_r) |=> wdt_reset_o)
    else $error("Overflow did not raise reset");

  a_second_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode_wr && mode_done_r && !stop_r && !src_stopped_i && !fired_r)
      |=> wdt_reset_o)
    else $error("Second mode write did not raise reset");

  a_stop_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    (stop_r && !pend_r) |=> !wdt_reset_o && $stable(cnt_r))
    else $error("Stopped watchdog reset or counted");

  a_opt_source: assert property (@(posedge mclk_i) disable iff (rst_i)
    always_run_opt_i && $past(always_run_opt_i) |-> !hs_sel_r && !stop_r)
    else $error("Always-run option left oscillator");

  a_mode_fixed: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_r[7:WDR_FIXED_LSB] == WDR_MODE_FIXED)
    else $error("Mode fixed bits changed");

  a_pulse_once: assert property (@(posedge mclk_i) disable iff (rst_i)
    wdt_reset_o |=> !wdt_reset_o [*2])
    else $error("Reset request not single pulse");

  a_start_long: assert property (@(posedge mclk_i)
    $fell(rst_i) |-> mode_r[WDR_CODE_MSB:0] == 3'h7 && !stop_r)
    else $error("Reset did not select longest interval");

endmodule

// ---- testbench/wdr_watchdog_tb_top.sv ----
`timescale 1ns/1ps
module wdr_watchdog_tb_top import wdr_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bit_acc = 1'b0;
  logic opt = 1'b0;
  logic osc = 1'b0;
  logic hs = 1'b0;
  logic stop_src = 1'b0;
  logic [7:0] rdata_o;
  logic stopped_o;
  logic wdt_reset_o;
  int fail_count = 0;
  int checked = 0;
  wdr_watchdog i_wdr_watchdog (.mclk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .bit_acc_i(bit_acc),
    .always_run_opt_i(opt), .osc_tick_i(osc), .hs_tick_i(hs),
    .src_stopped_i(stop_src), .rdata_o(rdata_o), .stopped_o(stopped_o),
    .wdt_reset_o(wdt_reset_o));
  always #12.5 clk = ~clk;
  task automatic conclude();
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_rst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic acc(input logic [15:0] a, input logic [7:0] d,
                     input logic w, input logic b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    bit_acc <= b;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    bit_acc <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    acc(a, 8'h00, 1'b0, 1'b0);
    cmp8(rdata_o, exp);
  endtask
  task automatic pulse(input logic exp);
    cmp1(wdt_reset_o, exp);
    if (exp) begin
      @(posedge clk);
      #1;
      cmp1(wdt_reset_o, 1'b0);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      osc <= 1'b1;
      @(posedge clk);
      osc <= 1'b0;
    end
    #1;
  endtask
  task automatic hticks(input int n);
    @(posedge clk);
    hs <= 1'b1;
    repeat (n) @(posedge clk);
    hs <= 1'b0;
    #1;
  endtask
  initial begin
    #(25 * 60000);
    fail_count++;
    conclude();
  end
  initial begin
    do_rst();
    rdchk(WDR_KEY_ADDR, WDR_KEY_RST);
    rdchk(WDR_MODE_ADDR, WDR_MODE_RST);
    acc(WDR_KEY_ADDR, WDR_KEY_VAL, 1'b1, 1'b0);
    pulse(1'b0);
    rdchk(WDR_KEY_ADDR, WDR_KEY_RST);
    acc(WDR_KEY_ADDR, 8'h55, 1'b1, 1'b0);
    pulse(1'b1);
    do_rst();
    acc(WDR_KEY_ADDR, WDR_KEY_VAL, 1'b1, 1'b1);
    pulse(1'b1);
    do_rst();
    ticks(500);
    pulse(1'b0);
    acc(WDR_MODE_ADDR, 8'h60, 1'b1, 1'b0);
    rdchk(WDR_MODE_ADDR, 8'h60);
    ticks(1000);
    acc(WDR_KEY_ADDR, WDR_KEY_VAL, 1'b1, 1'b0);
    ticks(2047);
    pulse(1'b0);
    ticks(1);
    pulse(1'b1);
    do_rst();
    acc(WDR_MODE_ADDR, 8'h70, 1'b1, 1'b0);
    cmp1(stopped_o, 1'b1);
    acc(WDR_KEY_ADDR, 8'h55, 1'b1, 1'b0);
    pulse(1'b0);
    acc(WDR_MODE_ADDR, 8'h60, 1'b1, 1'b0);
    pulse(1'b0);
    ticks(2100);
    pulse(1'b0);
    do_rst();
    acc(WDR_MODE_ADDR, 8'h61, 1'b1, 1'b0);
    @(posedge clk);
    stop_src <= 1'b1;
    acc(WDR_MODE_ADDR, 8'h61, 1'b1, 1'b0);
    pulse(1'b0);
    @(posedge clk);
    stop_src <= 1'b0;
    @(posedge clk);
    #1;
    pulse(1'b1);
    do_rst();
    acc(WDR_MODE_ADDR, 8'h68, 1'b1, 1'b0);
    ticks(100);
    hticks(8191);
    pulse(1'b0);
    hticks(1);
    pulse(1'b1);
    @(posedge clk);
    opt <= 1'b1;
    do_rst();
    ticks(1000);
    acc(WDR_MODE_ADDR, 8'h78, 1'b1, 1'b0);
    rdchk(WDR_MODE_ADDR, 8'h60);
    cmp1(stopped_o, 1'b0);
    hticks(2100);
    pulse(1'b0);
    repeat (2) begin
      ticks(1200);
      acc(WDR_KEY_ADDR, WDR_KEY_VAL, 1'b1, 1'b0);
    end
    pulse(1'b0);
    ticks(2047);
    pulse(1'b0);
    ticks(1);
    pulse(1'b1);
    do_rst();
    acc(WDR_MODE_ADDR, 8'h60, 1'b1, 1'b0);
    acc(WDR_MODE_ADDR, 8'h60, 1'b1, 1'b0);
    pulse(1'b1);
    conclude();
  end
endmodule
